// *** usp_defines.vh ***
`ifndef USP_DEFINES_VH
`define USP_DEFINES_VH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define USP_ADDR_CTRL      8'h00
`define USP_ADDR_DATA      8'h04
`define USP_ADDR_TIMER     8'h08

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define USP_CTRL_RX_DONE   1
`define USP_CTRL_TX_DONE   1
`define USP_BIT_RX_DONE    0
`define USP_BIT_TX_DONE    1
`define USP_BIT_RX_NINTH   2
`define USP_BIT_TX_NINTH   3
`define USP_BIT_RX_EN      4
`define USP_BIT_ADDR_FILT  5
`define USP_BIT_IRQ_EN     6
`define USP_BIT_FRAME9     7

// ---------------------------------------------------------------------------
// Timer configuration register fields
// ---------------------------------------------------------------------------
`define USP_TMR_RELOAD_LSB 0
`define USP_TMR_RELOAD_MSB 7
`define USP_TMR_SCALE_LSB  8
`define USP_TMR_SCALE_MSB  9
`define USP_TMR_SYSTEM_CLOCK_SOURCE     10
`define USP_TMR_RUN        11

// ---------------------------------------------------------------------------
// Reset values and timing constants
// ---------------------------------------------------------------------------
`define USP_RST_CTRL       8'h00
`define USP_RST_DATA       8'h00
`define USP_RST_TIMER      12'h000
`define USP_TMR_WRAP       9'h100
`define USP_DIV_12         6'h0C
`define USP_DIV_4          6'h04
`define USP_DIV_48         6'h30
`define USP_DIV_EXT        6'h08
`define USP_RESP_OKAY      2'h0
`define USP_RESP_SLVERR    2'h2

`endif

// *** usp_prescaler.v ***
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"

// Produces the baud timer's clock enable from the system clock or the
// external clock source: one pulse per 12, 4, 48 or 8 counted edges, or every clock when system_clock_source_sel is set.
module usp_prescaler (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [1:0] scale_sel,
  input  wire       system_clock_source_sel,
  input  wire       ext_clk_in,
  output wire       tick
);

  reg  [5:0] cnt_q;
  reg        ext_q;
  reg        ext_prev_q;
  reg  [5:0] div;
  wire       src_en;
  wire       wrap;

  // ---------------------------------------------------------------------------
  // Divide select
  // ---------------------------------------------------------------------------
  always @* begin
    case (scale_sel)
      2'b00:   div = `USP_DIV_12;
      2'b01:   div = `USP_DIV_4;
      2'b10:   div = `USP_DIV_48;
      default: div = `USP_DIV_EXT;
    endcase
  end

  // The external clock is counted on its rising edges.
  assign src_en = (scale_sel == 2'b11) ? (ext_q & ~ext_prev_q) : 1'b1;
  assign wrap   = src_en && (cnt_q == div - 6'h01);
  assign tick   = system_clock_source_sel | wrap;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q      <= 6'h00;
      ext_q      <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q      <= ext_clk_in;
      ext_prev_q <= ext_q;
      if (wrap) begin
        cnt_q <= 6'h00;
      end else if (src_en) begin
        cnt_q <= (cnt_q >= div) ? 6'h00 : cnt_q + 6'h01;
      end
    end
  end

endmodule // usp_prescaler

`default_nettype wire

// *** usp_reload_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"

// Eight-bit up counter that reloads on overflow and halves its overflow
// rate into a bit-time pulse. A restart forces a reload and clears the halver.
module usp_reload_timer (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       tick,
  input  wire       run,
  input  wire [7:0] reload,
  input  wire       restart,
  output wire       half_bit,
  output wire       bit_tick
);

  reg [7:0] cnt_q;
  reg       half_q;

  assign half_bit = run && tick && (cnt_q == 8'hFF);
  assign bit_tick = half_bit && half_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= 8'h00;
      half_q <= 1'b0;
    end else if (restart) begin
      cnt_q  <= reload;
      half_q <= 1'b0;
    end else if (half_bit) begin
      cnt_q  <= reload;
      half_q <= ~half_q;
    end else if (run && tick) begin
      cnt_q  <= cnt_q + 8'h01;
    end
  end

endmodule // usp_reload_timer

`default_nettype wire

// *** usp_remote_serial.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_remote_serial (
  input  wire logic clk,
  input  wire logic line_in,
  output var logic  line_out
);
  int         bit_clks = 8;
  int         frame_cnt = 0;
  logic [9:0] last_frame = 10'h000;
  logic [9:0] sh;
  int         k;

  initial line_out = 1'b1;

  // Sends one character; the line returns high after the last bit.
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth,
                      input logic stop);
    logic [10:0] f;
    f = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask

  // Samples ten bit slots after each start bit, in the middle of each.
  always begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk);
    for (k = 0; k < 10; k++) begin
      repeat (bit_clks) @(posedge clk);
      sh[k] = line_in;
    end
    last_frame = sh;
    frame_cnt++;
  end
endmodule // usp_remote_serial
`default_nettype wire

// *** usp_serial_port.v ***
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"

module usp_serial_port (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        external_clock_source,
  input  wire        receive_pin,
  output reg         transmit_pin,
  output wire        irq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA  = 2'd2;
  localparam ST_STOP  = 2'd3;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  reg  [7:0]  ctrl_q;
  reg  [7:0]  rx_latch_q;
  reg  [11:0] tmr_q;
  reg  [7:0]  aw_q;
  reg  [31:0] wd_q;
  reg  [3:0]  ws_q;
  reg         aw_have_q;
  reg         w_have_q;

  reg  [1:0]  tx_st_q;
  reg  [3:0]  tx_cnt_q;
  reg  [8:0]  tx_sh_q;
  reg         tx_go_q;

  reg  [1:0]  rx_st_q;
  reg  [4:0]  rx_cnt_q;
  reg  [8:0]  rx_sh_q;
  reg         rx_line_q;

  wire        tmr_tick;
  wire        tx_bit;
  wire        rx_half;
  wire        rx_start;
  wire        frame9;
  wire [3:0]  nbits;
  wire        wr_fire;
  wire        wr_ctrl;
  wire        wr_data;
  wire        wr_tmr;
  wire        tx_done_set;
  wire        rx_done_set;
  wire        rx_ninth_val;
  wire        rx_load_ok;

  // Compares two byte addresses at word granularity.
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a[7:2] == b[7:2]);
    end
  endfunction

  assign frame9 = ctrl_q[`USP_BIT_FRAME9];
  assign nbits  = frame9 ? 4'd9 : 4'd8;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_ctrl = wr_fire && ws_q[0] && is_addr(aw_q, `USP_ADDR_CTRL);
  assign wr_data = wr_fire && ws_q[0] && is_addr(aw_q, `USP_ADDR_DATA);
  assign wr_tmr  = wr_fire && is_addr(aw_q, `USP_ADDR_TIMER);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_q         <= 8'h00;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `USP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q      <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (is_addr(aw_q, `USP_ADDR_CTRL) || is_addr(aw_q, `USP_ADDR_DATA) ||
            is_addr(aw_q, `USP_ADDR_TIMER)) begin
          s_axi_bresp <= `USP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `USP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `USP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `USP_RESP_OKAY;
      if (is_addr(s_axi_araddr, `USP_ADDR_CTRL)) begin
        s_axi_rdata <= {24'h000000, ctrl_q};
      end else if (is_addr(s_axi_araddr, `USP_ADDR_DATA)) begin
        s_axi_rdata <= {24'h000000, rx_latch_q};
      end else if (is_addr(s_axi_araddr, `USP_ADDR_TIMER)) begin
        s_axi_rdata <= {20'h00000, tmr_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `USP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Baud generation
  // ---------------------------------------------------------------------------
  usp_prescaler u_prescaler (
    .clk        (clk),
    .rst_b      (rst_b),
    .scale_sel  (tmr_q[`USP_TMR_SCALE_MSB:`USP_TMR_SCALE_LSB]),
    .system_clock_source_sel (tmr_q[`USP_TMR_SYSTEM_CLOCK_SOURCE]),
    .ext_clk_in (external_clock_source),
    .tick       (tmr_tick)
  );

  usp_reload_timer u_tx_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (tmr_tick),
    .run      (tmr_q[`USP_TMR_RUN]),
    .reload   (tmr_q[`USP_TMR_RELOAD_MSB:`USP_TMR_RELOAD_LSB]),
    .restart  (1'b0),
    .half_bit (),
    .bit_tick (tx_bit)
  );

  // The receive timer restarts on a start edge so sampling lands mid-bit.
  usp_reload_timer u_rx_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .tick     (tmr_tick),
    .run      (tmr_q[`USP_TMR_RUN]),
    .reload   (tmr_q[`USP_TMR_RELOAD_MSB:`USP_TMR_RELOAD_LSB]),
    .restart  (rx_start),
    .half_bit (rx_half),
    .bit_tick ()
  );

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  assign tx_done_set = tx_bit && (tx_st_q == ST_DATA) && (tx_cnt_q == nbits - 4'd1);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q      <= ST_IDLE;
      tx_cnt_q     <= 4'd0;
      tx_sh_q      <= 9'h1FF;
      tx_go_q      <= 1'b0;
      transmit_pin <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_sh_q <= {ctrl_q[`USP_BIT_TX_NINTH], wd_q[7:0]};
        tx_go_q <= 1'b1;
      end
      if (tx_bit) begin
        case (tx_st_q)
          ST_IDLE: begin
            if (tx_go_q && !wr_data) begin
              tx_go_q      <= 1'b0;
              transmit_pin <= 1'b0;
              tx_st_q      <= ST_START;
            end
          end
          ST_START: begin
            transmit_pin <= tx_sh_q[0];
            tx_sh_q      <= {1'b1, tx_sh_q[8:1]};
            tx_cnt_q     <= 4'd0;
            tx_st_q      <= ST_DATA;
          end
          ST_DATA: begin
            if (tx_cnt_q == nbits - 4'd1) begin
              transmit_pin <= 1'b1;
              tx_st_q      <= ST_STOP;
            end else begin
              transmit_pin <= tx_sh_q[0];
              tx_sh_q      <= {1'b1, tx_sh_q[8:1]};
              tx_cnt_q     <= tx_cnt_q + 4'd1;
            end
          end
          default: begin
            tx_st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  assign rx_start = (rx_st_q == ST_IDLE) && ctrl_q[`USP_BIT_RX_EN] &&
                    rx_line_q && !receive_pin;
  assign rx_ninth_val = frame9 ? rx_sh_q[8] : receive_pin;
  assign rx_load_ok = !ctrl_q[`USP_BIT_RX_DONE] &&
                      (!ctrl_q[`USP_BIT_ADDR_FILT] || rx_ninth_val);
  // Only the mid-stop sample may set the flag, never the boundary before it.
  assign rx_done_set = rx_half && !rx_cnt_q[0] && (rx_st_q == ST_STOP) && rx_load_ok;

  // Odd half-bit overflows after the start edge fall mid-bit.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q    <= ST_IDLE;
      rx_cnt_q   <= 5'd0;
      rx_sh_q    <= 9'h000;
      rx_line_q  <= 1'b1;
      rx_latch_q <= `USP_RST_DATA;
    end else begin
      rx_line_q <= receive_pin;
      if (rx_start) begin
        rx_st_q  <= ST_START;
        rx_cnt_q <= 5'd0;
      end else if (rx_half) begin
        rx_cnt_q <= rx_cnt_q + 5'd1;
        if (!rx_cnt_q[0]) begin
          case (rx_st_q)
            ST_START: begin
              rx_cnt_q <= 5'd1;
              rx_st_q  <= receive_pin ? ST_IDLE : ST_DATA;
            end
            ST_DATA: begin
              rx_sh_q <= frame9 ? {receive_pin, rx_sh_q[8:1]}
                                : {1'b0, receive_pin, rx_sh_q[7:1]};
              if (rx_cnt_q == {nbits, 1'b0}) begin
                rx_st_q <= ST_STOP;
              end
            end
            ST_STOP: begin
              rx_st_q <= ST_IDLE;
              if (rx_load_ok) begin
                rx_latch_q <= rx_sh_q[7:0];
              end
            end
            default: begin
              rx_st_q <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control and timer registers
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `USP_RST_CTRL;
      tmr_q  <= `USP_RST_TIMER;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wd_q[7:0];
      end
      if (wr_tmr) begin
        if (ws_q[0]) tmr_q[7:0]  <= wd_q[7:0];
        if (ws_q[1]) tmr_q[11:8] <= wd_q[11:8];
      end
      if (tx_done_set) begin
        ctrl_q[`USP_BIT_TX_DONE] <= 1'b1;
      end
      if (rx_done_set) begin
        ctrl_q[`USP_BIT_RX_DONE]  <= 1'b1;
        ctrl_q[`USP_BIT_RX_NINTH] <= rx_ninth_val;
      end
    end
  end

  assign irq = ctrl_q[`USP_BIT_IRQ_EN] &
               (ctrl_q[`USP_BIT_TX_DONE] | ctrl_q[`USP_BIT_RX_DONE]);

endmodule // usp_serial_port

`default_nettype wire

// *** usp_serial_port_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        transmit_pin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rd_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0B
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
  irq_map_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 8'h00 |->
    $past(irq) == (s_axi_rdata[6] && (s_axi_rdata[1] || s_axi_rdata[0])))
    else $error("interrupt request wrong");

  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(irq));
  cover property ($fell(transmit_pin));
endmodule // usp_serial_port_checker

bind usp_serial_port usp_serial_port_checker u_usp_serial_port_checker (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .transmit_pin(transmit_pin), .irq(irq));
`default_nettype wire

// *** usp_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"
module usp_serial_port_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [1:0]  ec = 2'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         receive_pin, transmit_pin, irq;
  int          num_errors = 0;
  int          compares = 0;

  always #4 clk = ~clk;
  always @(posedge clk) ec <= ec + 2'h1;

  usp_serial_port u_usp_serial_port (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .external_clock_source(ec[1]),
    .receive_pin(receive_pin), .transmit_pin(transmit_pin), .irq(irq));
  usp_remote_serial u_usp_remote_serial (.clk(clk), .line_in(transmit_pin),
    .line_out(receive_pin));

  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic die;
    num_errors++;
    report_and_stop();
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // --------------------------------------------------------------------------
  // Register bus master
  // --------------------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 100) die();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        check(nm, s_axi_rdata & m, e);
        check(nm, {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100) die();
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic tx_check(input logic [7:0] c, input logic [7:0] d, input logic [9:0] e,
                          input int nb);
    int n;
    int c0;
    c0 = u_usp_remote_serial.frame_cnt;
    wr(`USP_ADDR_CTRL, {24'h0, c});
    wr(`USP_ADDR_DATA, {24'h0, d});
    for (n = 0; n < 3000 && transmit_pin !== 1'b0; n++) @(posedge clk);
    if (n == 3000) die();
    if (nb > 0) begin
      repeat (8 * nb - 7) @(posedge clk);
      rd_chk("tx_done_early", `USP_ADDR_CTRL, 32'h2, 32'h0, `USP_RESP_OKAY);
      repeat (3) @(posedge clk);
      rd_chk("tx_done_stop", `USP_ADDR_CTRL, 32'h2, 32'h2, `USP_RESP_OKAY);
    end
    for (n = 0; n < 3000 && u_usp_remote_serial.frame_cnt == c0; n++) @(posedge clk);
    if (n == 3000) die();
    check("tx_frame", {22'h0, u_usp_remote_serial.last_frame}, {22'h0, e});
  endtask

  task automatic rx_case(input logic [7:0] d, input logic nine, input logic ninth,
                         input logic stop, input logic [7:0] ed, input logic [31:0] m,
                         input logic [31:0] ec_exp);
    u_usp_remote_serial.send(d, nine, ninth, stop);
    repeat (4) @(posedge clk);
    rd_chk("rx_data", `USP_ADDR_DATA, 32'hFFFFFFFF, {24'h0, ed}, `USP_RESP_OKAY);
    rd_chk("rx_ctrl", `USP_ADDR_CTRL, m, ec_exp, `USP_RESP_OKAY);
  endtask

  task automatic t_regs;
    logic [1:0] r;
    rd_chk("ctrl_rst", `USP_ADDR_CTRL, 32'hFFFFFFFF, 32'h0, `USP_RESP_OKAY);
    rd_chk("data_rst", `USP_ADDR_DATA, 32'hFFFFFFFF, 32'h0, `USP_RESP_OKAY);
    rd_chk("timer_rst", `USP_ADDR_TIMER, 32'hFFFFFFFF, 32'h0, `USP_RESP_OKAY);
    rd_chk("unmapped_rd", 8'h0C, 32'hFFFFFFFF, 32'h0, `USP_RESP_SLVERR);
    axi_wr(8'h0C, 32'h5A, r);
    check("unmapped_wr", {30'h0, r}, {30'h0, `USP_RESP_SLVERR});
    wr(`USP_ADDR_TIMER, 32'hCFC);
    rd_chk("timer_rw", `USP_ADDR_TIMER, 32'hFFF, 32'hCFC, `USP_RESP_OKAY);
  endtask

  task automatic t_baud;
    logic [11:0] cfg [6] = '{12'hCFC, 12'hCFE, 12'h8FF, 12'h9FF, 12'hAFF, 12'hBFF};
    int          bc [6] = '{8, 4, 24, 8, 96, 64};
    for (int i = 0; i < 6; i++) begin
      wr(`USP_ADDR_TIMER, {20'h0, cfg[i]});
      u_usp_remote_serial.bit_clks = bc[i];
      tx_check(8'h00, 8'hA5 ^ i[7:0], {2'b11, 8'hA5 ^ i[7:0]}, 0);
    end
    wr(`USP_ADDR_TIMER, 32'hCFC);
    u_usp_remote_serial.bit_clks = 8;
  endtask

  task automatic t_rx;
    rx_case(8'h3C, 0, 0, 1, 8'h00, 32'h1, 32'h0);
    wr(`USP_ADDR_CTRL, 32'h10);
    rx_case(8'h3C, 0, 0, 1, 8'h3C, 32'h5, 32'h5);
    rx_case(8'hC3, 0, 0, 1, 8'h3C, 32'h5, 32'h5);
    wr(`USP_ADDR_CTRL, 32'h30);
    rx_case(8'h5A, 0, 0, 0, 8'h3C, 32'h1, 32'h0);
    wr(`USP_ADDR_CTRL, 32'hB0);
    rx_case(8'h11, 1, 0, 1, 8'h3C, 32'h1, 32'h0);
    rx_case(8'h22, 1, 1, 0, 8'h22, 32'h5, 32'h5);
    wr(`USP_ADDR_CTRL, 32'h90);
    rx_case(8'h44, 1, 0, 1, 8'h44, 32'h5, 32'h1);
  endtask

  task automatic t_irq;
    wr(`USP_ADDR_CTRL, 32'hD0);
    check("irq_idle", {31'h0, irq}, 32'h0);
    u_usp_remote_serial.send(8'h66, 1, 1, 1);
    repeat (4) @(posedge clk);
    check("irq_rx", {31'h0, irq}, 32'h1);
    rd_chk("flag_kept", `USP_ADDR_CTRL, 32'h1, 32'h1, `USP_RESP_OKAY);
    check("irq_kept", {31'h0, irq}, 32'h1);
    tx_check(8'h40, 8'h77, {2'b11, 8'h77}, 0);
    check("irq_tx", {31'h0, irq}, 32'h1);
    tx_check(8'h00, 8'h78, {2'b11, 8'h78}, 0);
    check("irq_masked", {31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_baud();
    tx_check(8'h88, 8'h96, {2'b11, 8'h96}, 10);
    tx_check(8'h80, 8'h69, {2'b10, 8'h69}, 10);
    tx_check(8'h08, 8'hF0, {2'b11, 8'hF0}, 9);
    t_rx();
    t_irq();
    report_and_stop();
  end
endmodule // usp_serial_port_tb_top
`default_nettype wire
